// ---- design/osd_detector.sv ----
// original size detector: sync, event detect, decode, hold
// assumes all sensor, cover, key and tray inputs are asynchronous pins
`timescale 1ns/100ps
module osd_detector (
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire osd_pkg::osd_sensors_type sensors_in,
  input  wire logic                   cover_closed_in,
  input  wire logic                   start_key_in,
  input  wire logic                   bypass_tray_in,
  output      osd_pkg::osd_result_type result_out,
  output      logic                   result_valid_out
);

  localparam int N = osd_pkg::SENSE_W + 1;

  logic [N-1:0] raw;
  logic [N-1:0] s1_q, s2_q, s3_q;
  logic [N-1:0] s1_d, s2_d, s3_d;
  logic [N-1:0] clean_q, clean_d;
  logic         prev_cover_q, prev_cover_d, prev_start_q, prev_start_d;
  osd_pkg::osd_result_type res_q, res_d;
  logic         valid_q, valid_d;
  logic         cover_rise, start_rise, sample;
  osd_pkg::osd_sensors_type sens;

  assign raw = {bypass_tray_in, start_key_in, cover_closed_in, sensors_in};

  // decode one sample; unknown gives flag and zero code
  function automatic osd_pkg::osd_result_type decode(input osd_pkg::osd_sensors_type s);
    osd_pkg::osd_result_type r;
    r = '{size_code: osd_pkg::CODE_RESET, undetectable: 1'b0, full_area: 1'b0};
    case ({s.length_sensor_long, s.length_sensor_mid, s.length_sensor_short,
           s.width_sensor_second, s.width_sensor_first})
      5'b11111: r.size_code = osd_pkg::CODE_A3;
      5'b11101: r.size_code = osd_pkg::CODE_B4;
      5'b11100: r.size_code = osd_pkg::CODE_F4;
      5'b01100: r.size_code = osd_pkg::CODE_A4_L;
      5'b00100: r.size_code = osd_pkg::CODE_B5_L;
      5'b00011: r.size_code = osd_pkg::CODE_A4_S;
      5'b00001: r.size_code = osd_pkg::CODE_B5_S;
      5'b00000: r.size_code = osd_pkg::CODE_A5;
      default:  r.undetectable = 1'b1;
    endcase
    return r;
  endfunction : decode

  // three stages; a bit changes only when stages two and three agree
  always_comb begin
    s1_d    = raw;
    s2_d    = s1_q;
    s3_d    = s2_q;
    clean_d = clean_q;
    for (int i = 0; i < N; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s3_q[i];
      end
    end
  end

  // chain runs through reset: a cover already closed at release is no edge
  always_ff @(posedge clk_in) begin
    s1_q    <= s1_d;
    s2_q    <= s2_d;
    s3_q    <= s3_d;
    clean_q <= clean_d;
  end

  assign sens       = osd_pkg::osd_sensors_type'(clean_q[4:0]);
  assign cover_rise = clean_q[osd_pkg::BIT_COVER] & ~prev_cover_q;
  // key counts only while cover is open
  assign start_rise = clean_q[osd_pkg::BIT_START] & ~prev_start_q & ~clean_q[osd_pkg::BIT_COVER];
  assign sample     = cover_rise | start_rise;

  always_comb begin
    prev_cover_d = clean_q[osd_pkg::BIT_COVER];
    prev_start_d = clean_q[osd_pkg::BIT_START];
    res_d        = res_q;
    valid_d      = valid_q;
    if (sample) begin
      valid_d = 1'b1;
      if (clean_q[osd_pkg::BIT_TRAY]) begin
        // tray overrides the sensors: lengthwise, largest area
        res_d = '{size_code: osd_pkg::CODE_A3, undetectable: 1'b0, full_area: 1'b1};
      end else begin
        res_d = decode(sens);
      end
    end
  end

  // edge history tracks the filtered pins even in reset
  always_ff @(posedge clk_in) begin
    prev_cover_q <= prev_cover_d;
    prev_start_q <= prev_start_d;
    if (!reset_n_in) begin
      res_q        <= '0;
      valid_q      <= 1'b0;
    end else begin
      res_q        <= res_d;
      valid_q      <= valid_d;
    end
  end

  assign result_out       = res_q;
  assign result_valid_out = valid_q;

endmodule : osd_detector

// ---- design/osd_pkg.sv ----
// constants and carrier types for the original size detector
// assumes one 100 MHz system clock and sensor pins outside that domain
package osd_pkg;

  localparam int          CODE_W        = 8;
  localparam logic [7:0]  CODE_A3       = 8'h84; // 132
  localparam logic [7:0]  CODE_B4       = 8'h8d; // 141
  localparam logic [7:0]  CODE_F4       = 8'ha5; // 165
  localparam logic [7:0]  CODE_A4_L     = 8'h85; // 133
  localparam logic [7:0]  CODE_B5_L     = 8'h8e; // 142
  localparam logic [7:0]  CODE_A4_S     = 8'h05; // 5
  localparam logic [7:0]  CODE_B5_S     = 8'h0e; // 14
  localparam logic [7:0]  CODE_A5       = 8'h80; // 128
  localparam logic [7:0]  CODE_RESET    = 8'h00;
  localparam int          SYNC_STAGES   = 3;
  localparam int          SENSE_W       = 7;
  localparam int          BIT_COVER     = 5;
  localparam int          BIT_START     = 6;
  localparam int          BIT_TRAY      = 7;

  // order: bypass, start, cover, long, mid, short, width_second, width_first
  typedef struct packed {
    logic length_sensor_long;
    logic length_sensor_mid;
    logic length_sensor_short;
    logic width_sensor_second;
    logic width_sensor_first;
  } osd_sensors_type;

  typedef struct packed {
    logic [CODE_W-1:0] size_code;
    logic              undetectable;
    logic              full_area;
  } osd_result_type;

endpackage : osd_pkg

// ---- test/osd_asserts.sv ----
// port checker for osd_detector
// assumes one clock, sync low reset
`timescale 1ns/100ps
module osd_asserts (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire osd_pkg::osd_sensors_type sensors_in,
  input wire logic cover_closed_in,
  input wire logic start_key_in,
  input wire logic bypass_tray_in,
  input wire osd_pkg::osd_result_type result_out,
  input wire logic result_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_reset_clear: assert property (disable iff (1'b0) !reset_n_in |=> {result_out, result_valid_out} == '0)
    else $error("not cleared");
  a_valid_hold: assert property (result_valid_out |=> result_valid_out) else $error("valid lost");
  a_undet_zero: assert property (result_out[1] |-> result_out == 10'h002) else $error("bad undet");
  a_tray_code: assert property (result_out[0] |-> result_out == 10'h211) else $error("bad tray");
  a_change_cause: assert property ($changed(result_out) |-> $past(cover_closed_in, 5) || $past(start_key_in, 5))
    else $error("stray change");
  a_close_code: assert property ($rose(cover_closed_in) && !bypass_tray_in && sensors_in == 5'h1f |-> ##[4:7]
    result_out == 10'h210) else $error("no close sample");
  a_open_start: assert property (!cover_closed_in && sensors_in == 5'h03 && $rose(start_key_in) |-> ##[4:7]
    result_out == 10'h014) else $error("no key sample");
  a_tray_full: assert property ($rose(cover_closed_in) && bypass_tray_in |-> ##[4:7] result_out == 10'h211)
    else $error("tray ignored");
  cover property (result_out[1]);
  cover property (result_out[0]);
  cover property ($rose(start_key_in) && !cover_closed_in);
endmodule : osd_asserts
bind osd_detector osd_asserts osd_asserts_inst (.*);

// ---- test/osd_far.sv ----
// far side: paper, cover, key and tray pins
// assumes the bench calls act in order
`timescale 1ns/100ps
module osd_far (
  input  wire logic       clk_in,
  output logic      [7:0] pins_out
);
  initial pins_out = '0;
  // pins: tray, key, cover, sensors; paper settles 8 cycles before the event
  task automatic act(input logic [7:0] p);
    @(posedge clk_in);
    pins_out <= {p[7], pins_out[6:5], p[4:0]};
    repeat (8) @(posedge clk_in);
    pins_out[6:5] <= p[6:5];
    repeat (12) @(posedge clk_in);
    pins_out[6] <= 1'b0;
  endtask : act
endmodule : osd_far

// ---- test/original_size_detector_bench.sv ----
// self-checking bench for osd_detector
// assumes osd_far drives every sampled pin
`timescale 1ns/100ps
module original_size_detector_bench;
  logic clk_in = 0;
  logic reset_n_in = 0;
  logic [7:0] p;
  logic v;
  osd_pkg::osd_result_type r;
  int bad_count = 0;
  int tests_run = 0;
  // pins on close, then expected result
  logic [17:0] tv [10] = '{18'h0fe10, 18'h0f634, 18'h0f294, 18'h0b214, 18'h09238,
                           18'h08c14, 18'h08438, 18'h08200, 18'h0c002, 18'h28211};
  initial forever #5 clk_in = ~clk_in;
  osd_far osd_far_inst (.clk_in(clk_in), .pins_out(p));
  osd_detector osd_detector_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .sensors_in(p[4:0]),
    .cover_closed_in(p[5]), .start_key_in(p[6]), .bypass_tray_in(p[7]), .result_out(r), .result_valid_out(v));
  task automatic chk(input logic [10:0] g, e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic t_table;
    foreach (tv[i]) begin
      osd_far_inst.act(tv[i][17:10] & 8'hdf);
      osd_far_inst.act(tv[i][17:10]);
      chk({r, v}, {tv[i][9:0], 1'b1});
    end
    $display("size table done");
  endtask : t_table
  task automatic t_start;
    osd_far_inst.act(8'h03);
    osd_far_inst.act(8'h43);
    chk({r, v}, 11'h029);
    osd_far_inst.act(8'h23);
    osd_far_inst.act(8'h60);
    chk({r, v}, 11'h029);
    $display("start key done");
  endtask : t_start
  task automatic t_reset;
    reset_n_in <= 0;
    repeat (4) @(posedge clk_in);
    chk({r, v}, 11'h000);
    reset_n_in <= 1;
    repeat (10) @(posedge clk_in);
    chk({r, v}, 11'h000);
    $display("mid reset done");
  endtask : t_reset
  task automatic test_done;
    $display("%0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(posedge clk_in);
    chk({r, v}, 11'h000);
    reset_n_in <= 1;
    t_table;
    t_start;
    t_reset;
    test_done;
  end
  // tests need about 5.3 us
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
endmodule : original_size_detector_bench
